// >>> aoc_link_model.sv
module aoc_link_model
    import aoc_pkg::*;
(
    input  wire logic  clk,         // system clock
    input  wire logic  link_tx,     // card serial out
    input  wire logic  link_oe,     // card driver enable
    output logic       link_rx,     // line toward the card
    output logic       start_ok,    // start bit low at mid bit
    output logic [1:0] first_bits,  // first two data bits
    output logic       got          // capture finished
);
    // mainframe side: the line idles high and only a driving board is
    // listened to; a full frame is too long for a short run, so only the
    // start bit and two data bits are taken
    initial
    begin
        link_rx = 1'b1;
        start_ok = 1'b0;
        first_bits = 2'b00;
        got = 1'b0;
        do
            @(posedge clk);
        while (!(link_oe && !link_tx));
        repeat (HALF_CYC) @(posedge clk);
        start_ok = !link_tx;
        repeat (BIT_CYC) @(posedge clk);
        first_bits[0] = link_tx;
        repeat (BIT_CYC) @(posedge clk);
        first_bits[1] = link_tx;
        got = 1'b1;
    end
endmodule

// >>> aoc_pkg.sv
package aoc_pkg;

    // clock and serial link timing
    localparam int CLK_HZ   = 250_000_000;
    localparam int BAUD_HZ  = 9600;
    localparam int BIT_CYC  = CLK_HZ / BAUD_HZ;
    localparam int HALF_CYC = BIT_CYC / 2;

    // power-on qualification delay in whole cycles; the product is kept
    // small so it cannot overflow a 32-bit int
    localparam int POR_MS  = 50;
    localparam int POR_CYC = (CLK_HZ / 1000) * POR_MS;

    // register byte addresses
    localparam logic [7:0] OFF_PORT1  = 8'h00;
    localparam logic [7:0] OFF_PORT2  = 8'h04;
    localparam logic [7:0] OFF_LOW    = 8'h08;
    localparam logic [7:0] OFF_TX     = 8'h0C;
    localparam logic [7:0] OFF_RX     = 8'h10;
    localparam logic [7:0] OFF_SWITCH = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // port bit positions
    localparam int P1_ERR    = 0;
    localparam int P1_RD     = 1;
    localparam int P1_DRV    = 3;
    localparam int P1_SWRD_N = 5;
    localparam int P2_STB_LO = 4;
    localparam int P2_ZERO   = 7;

    // reset values
    localparam logic [7:0] P1_RST = 8'h20;
    localparam logic [7:0] P2_RST = 8'h80;

    // initialize command byte, value is arbitrary
    localparam logic [7:0] INIT_CMD = 8'hFF;

    localparam int NCH    = 4;
    localparam int WORD_W = 12;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_DATA  = 5'h04,
        ST_PAR   = 5'h08,
        ST_STOP  = 5'h10
    } aoc_ser_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } aoc_bus_t;

    typedef struct packed {
        logic [2:0] rx_sync;
        logic       rx_lvl;
        aoc_ser_t   rx_st;
        logic [15:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic       rx_par;
        logic       rx_pbad;
        logic [7:0] rx_data;
        logic       rx_ready;
        logic       rx_new;
        logic       ovr;
        logic       frm;
        logic       perr;
        aoc_ser_t   tx_st;
        logic [15:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic       tx_par;
        logic       tx_line;
        logic       tx_done;
    } aoc_uart_st_t;

    typedef struct packed {
        logic [2:0]      sup_sync;
        logic            sup_lvl;
        logic [23:0]     por_cnt;
        logic            por_ok;
        logic [2:0][7:0] sw_sync;
        logic [7:0]      sw_lvl;
        logic [7:0]      p1;
        logic [7:0]      p2;
        logic [3:0]      stb_prev;
        logic [7:0]      low_byte;
        logic [3:0]      nibble;
        logic [3:0][11:0] chan;
        logic [3:0][11:0] dac;
        logic [31:0]     rdata;
    } aoc_top_st_t;

endpackage

// >>> aoc_top.sv
// Operation
// - hold digital logic disabled until 50 ms after supply is good
// - supply falling below operating level disables at once
// - reset output low active, high only after delay, low on dip
// - receiver raises data-ready flag when a word is complete
// - received word fetched by the port 1 bit 1 read strobe
// - port 1 bit 0 reports overrun, framing or parity error
// - port 1 bit 3 enables the link driver before sending
// - transmit load strobe captures one byte, then 8 bits shift out
// - driver disabled after the transmission ends
// - switches reach the data bus only on read with port 1 bit 5 low
// - switch address compared with address received over the link
// - switch lines are active low, value read inverted
// - 12-bit word built first from an 8-bit low byte latch
// - remaining 4 bits latched from port 2 bits 3 to 0
// - port 2 bits 4 to 7 strobe the word into channel latches
// - bit 6 loads channel 1, bit 5 loads channel 2
// - port 2 bit 7 high forces all outputs to zero scale
// - port 2 bit 7 comes up high at power-on
// - initialize command from the mainframe drives outputs to zero
module aoc_top
    import aoc_pkg::*;
#(
    parameter int POR_CYCLES = POR_CYC
)
(
    input  wire logic        clk,         // 250 MHz system clock
    input  wire logic        rst_n,       // sync reset, low active
    input  wire aoc_bus_t    bus,         // register bus request
    output logic [31:0]      rdata,       // read data, cycle after rd
    input  wire logic        supply_ok,   // logic supply in tolerance
    input  wire logic [7:0]  switch_n,    // decade switches, low = one
    input  wire logic        link_rx,     // from link receiver
    output logic             link_tx,     // to link driver
    output logic             link_oe,     // link driver enable
    output logic             por_rst_n,   // qualified reset, low active
    output logic [3:0][11:0] dac_code,    // per-channel converter words
    output logic             zero_scale   // outputs forced to zero
);

    aoc_top_st_t s;
    aoc_top_st_t next_s;

    logic       core_rst_n;
    logic       pop;
    logic       tx_load;
    logic [7:0] rx_data;
    logic       rx_ready;
    logic       rx_new;
    logic       rx_err;
    logic       tx_line;
    logic       tx_busy;
    logic       tx_done;
    logic [7:0] sw_val;
    logic       addr_match;

    // register hit on a given offset
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        reg_hit = (a == off);
    endfunction

    // rising edge of one strobe bit against its previous level
    function automatic logic rose(input logic now, input logic prev);
        rose = now & ~prev;
    endfunction

    // everything besides the supply and switch synchronisers and the
    // qualification counter is held in reset until the supply has been good long enough
    assign core_rst_n = rst_n & s.por_ok;

    // switch value, inverted because a one reads as a low level
    assign sw_val = ~s.sw_lvl;

    // address match against the last word from the link
    assign addr_match = rx_ready & (rx_data == sw_val);

    // bus strobes decoded into block actions
    assign pop     = bus.wr & reg_hit(bus.addr, OFF_PORT1)
                   & bus.wdata[P1_RD];
    assign tx_load = bus.wr & reg_hit(bus.addr, OFF_TX);

    aoc_uart u_uart (
        .clk      (clk),
        .rst_n    (core_rst_n),
        .rx_pin   (link_rx),
        .pop      (pop),
        .load     (tx_load),
        .tx_byte  (bus.wdata[7:0]),
        .rx_data  (rx_data),
        .rx_ready (rx_ready),
        .rx_new   (rx_new),
        .rx_err   (rx_err),
        .tx_line  (tx_line),
        .tx_busy  (tx_busy),
        .tx_done  (tx_done)
    );

    // next state of the whole card
    always_comb
    begin
        next_s = s;

        // supply level through three stages, counted once two agree
        next_s.sup_sync = {s.sup_sync[1:0], supply_ok};
        if (s.sup_sync[1] == s.sup_sync[2])
            next_s.sup_lvl = s.sup_sync[2];

        // qualification counter restarts on every dip
        if (!s.sup_lvl)
        begin
            next_s.por_cnt = 24'h000000;
            next_s.por_ok  = 1'b0;
        end
        else if (s.por_cnt >= 24'(POR_CYCLES - 1))
            next_s.por_ok  = 1'b1;
        else
            next_s.por_cnt = s.por_cnt + 24'h000001;

        // switches are static but still come from outside the clock
        next_s.sw_sync = {s.sw_sync[1:0], switch_n};
        for (int i = 0; i < 8; i++)
        begin
            if (s.sw_sync[1][i] == s.sw_sync[2][i])
                next_s.sw_lvl[i] = s.sw_sync[2][i];
        end

        // driver released by hardware after the stop bit
        if (tx_done)
            next_s.p1[P1_DRV] = 1'b0;

        // register writes
        if (bus.wr)
        begin
            if (reg_hit(bus.addr, OFF_PORT1))
            begin
                next_s.p1[P1_DRV]    = bus.wdata[P1_DRV];
                next_s.p1[P1_SWRD_N] = bus.wdata[P1_SWRD_N];
            end
            if (reg_hit(bus.addr, OFF_PORT2))
            begin
                next_s.p2     = bus.wdata[7:0];
                next_s.nibble = bus.wdata[3:0];
            end
            if (reg_hit(bus.addr, OFF_LOW))
                next_s.low_byte = bus.wdata[7:0];
        end

        // an initialize command raises the zero line; it wins over a
        // software write landing in the same cycle
        if (rx_new && rx_data == INIT_CMD)
            next_s.p2[P2_ZERO] = 1'b1;

        // channel strobes: bit 7 ch0, bit 6 ch1, bit 5 ch2, bit 4 ch3
        next_s.stb_prev = s.p2[7:P2_STB_LO];
        for (int c = 0; c < NCH; c++)
        begin
            if (rose(s.p2[7 - c], s.stb_prev[3 - c]))
                next_s.chan[c] = {s.nibble, s.low_byte};
        end

        // nibble on top, so all zeros gives zero scale
        for (int c = 0; c < NCH; c++)
        begin
            next_s.dac[c] = s.p2[P2_ZERO] ? 12'h000
                          : next_s.chan[c];
        end

        // read data stands in the cycle after the strobe only
        next_s.rdata = 32'h00000000;
        if (bus.rd)
        begin
            case (1'b1)
                reg_hit(bus.addr, OFF_PORT1):
                begin
                    next_s.rdata[P1_ERR]    = rx_err;
                    next_s.rdata[P1_DRV]    = s.p1[P1_DRV];
                    next_s.rdata[P1_SWRD_N] = s.p1[P1_SWRD_N];
                end
                reg_hit(bus.addr, OFF_PORT2):
                    next_s.rdata[7:0] = s.p2;
                reg_hit(bus.addr, OFF_LOW):
                    next_s.rdata[7:0] = s.low_byte;
                reg_hit(bus.addr, OFF_RX):
                    next_s.rdata[7:0] = rx_data;
                reg_hit(bus.addr, OFF_SWITCH):
                    // buffers drive only with the enable bit low
                    if (!s.p1[P1_SWRD_N])
                        next_s.rdata[7:0] = sw_val;
                reg_hit(bus.addr, OFF_STATUS):
                    next_s.rdata[4:0] = {addr_match, tx_busy,
                                         rx_ready, s.sup_lvl,
                                         s.por_ok};
                default:
                    next_s.rdata = 32'h00000000;
            endcase
        end

        // while unqualified, the core sits at its reset values
        if (!s.por_ok)
        begin
            next_s.p1       = P1_RST;
            next_s.p2       = P2_RST;
            next_s.stb_prev = 4'h8;
            next_s.low_byte = 8'h00;
            next_s.nibble   = 4'h0;
            next_s.chan     = '0;
            next_s.dac      = '0;
            next_s.rdata    = 32'h00000000;
        end
    end

    // one register for all state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s          <= '0;
            s.p1       <= P1_RST;
            s.p2       <= P2_RST;
            s.stb_prev <= 4'h8;
        end
        else
            s <= next_s;
    end

    // the raw supply input pulls the reset low without waiting for
    // the synchroniser; release still needs the full count
    assign por_rst_n  = s.por_ok & supply_ok;
    assign rdata      = s.rdata;
    assign link_tx    = tx_line;
    assign link_oe    = s.p1[P1_DRV];
    assign dac_code   = s.dac;
    assign zero_scale = s.p2[P2_ZERO];

endmodule

// >>> aoc_top_props.sv
module aoc_top_props
    import aoc_pkg::*;
#(
    parameter int POR_CYCLES = POR_CYC
)
(
    input wire logic             clk,        // system clock
    input wire logic             rst_n,      // sync reset, low active
    input wire aoc_bus_t         bus,        // register request
    input wire logic [31:0]      rdata,      // read data
    input wire logic             supply_ok,  // supply good
    input wire logic [7:0]       switch_n,   // decade switches
    input wire logic             link_rx,    // serial in
    input wire logic             link_tx,    // serial out
    input wire logic             link_oe,    // driver enable
    input wire logic             por_rst_n,  // qualified reset
    input wire logic [3:0][11:0] dac_code,   // channel words
    input wire logic             zero_scale  // outputs forced zero
);
    logic [31:0] good_cnt;
    logic [31:0] low_cnt;
    logic [7:0]  since_p2;
    logic [7:0]  hi_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // helper counters; the small ones saturate so they never wrap
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            good_cnt <= 32'h0;
            low_cnt  <= 32'h0;
            since_p2 <= 8'hFF;
            hi_cnt   <= 8'h00;
        end
        else
        begin
            good_cnt <= supply_ok ? good_cnt + 32'h1 : 32'h0;
            low_cnt  <= link_tx ? 32'h0 : low_cnt + 32'h1;
            if (bus.wr && bus.addr == OFF_PORT2)
                since_p2 <= 8'h00;
            else if (since_p2 != 8'hFF)
                since_p2 <= since_p2 + 8'h01;
            if (!por_rst_n)
                hi_cnt <= 8'h00;
            else if (hi_cnt != 8'hFF)
                hi_cnt <= hi_cnt + 8'h01;
        end
    end

    AST_POR_DIP: assert property (
        !supply_ok |-> !por_rst_n)
        else $error("reset out high while supply is low");
    AST_POR_WAIT: assert property (
        $rose(por_rst_n) |-> good_cnt >= POR_CYCLES)
        else $error("reset out released too early");
    AST_DIP_SAFE: assert property (
        $fell(por_rst_n) |->
            ##[1:6] (zero_scale && dac_code == '0 && !link_oe))
        else $error("outputs not made safe after supply dip");
    AST_ZERO_FORCE: assert property (
        zero_scale [*3] |-> dac_code == '0)
        else $error("channel word nonzero while forced to zero");
    AST_RD_IDLE: assert property (
        !$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
    AST_SW_READ: assert property (
        $past(bus.rd && bus.addr == OFF_SWITCH) |->
            rdata == 32'h0 || rdata == {24'h0, ~$past(switch_n, 4)})
        else $error("switch read not inverted switch value");
    AST_TX_NEEDS_OE: assert property (
        $fell(link_tx) |-> link_oe)
        else $error("serial out moved with driver off");
    AST_TX_BITLEN: assert property (
        $rose(link_tx) |-> low_cnt % BIT_CYC == 0)
        else $error("serial low run not whole bit times");
    AST_OE_FALL_IDLE: assert property (
        $fell(link_oe) |-> link_tx)
        else $error("driver dropped while line low");
    AST_CH_LOAD: assert property (
        $changed(dac_code) && hi_cnt > 8'd8 |-> since_p2 <= 8'd4)
        else $error("channel word changed without port 2 write");

    cover property ($rose(por_rst_n));
    cover property ($fell(por_rst_n));
    cover property ($rose(link_tx));
    cover property ($changed(dac_code) && !zero_scale);
endmodule

bind aoc_top aoc_top_props #(.POR_CYCLES(POR_CYCLES)) i_props (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .supply_ok(supply_ok), .switch_n(switch_n), .link_rx(link_rx),
    .link_tx(link_tx), .link_oe(link_oe), .por_rst_n(por_rst_n),
    .dac_code(dac_code), .zero_scale(zero_scale));

// >>> aoc_top_tb.sv
module aoc_top_tb
    import aoc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int POR_SIM = 20;

    logic             clk;
    logic             rst_n;
    logic             supply_ok;
    logic             link_rx;
    logic             link_tx;
    logic             link_oe;
    logic             por_rst_n;
    logic             zero_scale;
    logic             start_ok;
    logic             got;
    logic [1:0]       first_bits;
    logic [7:0]       switch_n;
    logic [31:0]      rdata;
    logic [3:0][11:0] dac_code;
    aoc_bus_t         bus;
    logic [15:0]      seq [8];
    int               num_errors;
    int               n_checks;
    int               n;

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    aoc_top #(.POR_CYCLES(POR_SIM)) i_dut (
        .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .supply_ok(supply_ok), .switch_n(switch_n), .link_rx(link_rx),
        .link_tx(link_tx), .link_oe(link_oe), .por_rst_n(por_rst_n),
        .dac_code(dac_code), .zero_scale(zero_scale));

    aoc_link_model i_link (
        .clk(clk), .link_tx(link_tx), .link_oe(link_oe), .link_rx(link_rx),
        .start_ok(start_ok), .first_bits(first_bits), .got(got));

    // wide enough for the zero line beside all four channel words
    task automatic chk(input string what, input logic [48:0] seen,
                       input logic [48:0] expv);
        n_checks++;
        if (seen !== expv)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, expv, seen);
        end
    endtask

    // one write cycle, then one idle cycle so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: {24'h0, d}, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] expv,
                      input string what);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk(what, {16'h0, rdata}, {16'h0, expv});
        @(posedge clk);
    endtask

    task automatic wait_por(output int cnt);
        cnt = 0;
        while (por_rst_n !== 1'b1 && cnt < 200)
        begin
            @(negedge clk);
            cnt++;
        end
        // a reset that never lifts counts against the run
        if (por_rst_n !== 1'b1)
            num_errors++;
        @(posedge clk);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        supply_ok = 1'b1;
        switch_n = ~8'h42; // mainframe calls this card 42
        bus = '0;
        num_errors = 0;
        n_checks = 0;
        seq = '{16'h0834, 16'h0405, 16'h0445, 16'h08AB,
                16'h040C, 16'h042C, 16'h041F, 16'h0481};
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("reset pins", {por_rst_n, zero_scale, link_oe, link_tx}, 4'b0101);
        chk("dac in reset", dac_code, 48'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_por(n);
        chk("por delay", n >= POR_SIM && n <= POR_SIM + 8, 1);
        $display("test power-on done");
        rd(OFF_PORT1, 32'h20, "port1 reset");
        rd(OFF_PORT2, 32'h80, "port2 reset");
        rd(OFF_SWITCH, 32'h0, "switch disabled");
        rd(OFF_STATUS, 32'h3, "status idle");
        rd(8'h1C, 32'h0, "unmapped");
        rd(OFF_TX, 32'h0, "tx write only");
        wr(OFF_PORT1, 8'h00);
        rd(OFF_SWITCH, 32'h42, "switch value");
        rd(OFF_PORT1, 32'h0, "rx error clear");
        $display("test registers done");
        // low byte, nibble and strobes: ch1 534, ch2 CAB, ch3 FAB, ch0 1AB
        foreach (seq[i])
            wr(seq[i][15:8], seq[i][7:0]);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("forced zero", {zero_scale, dac_code}, {1'b1, 48'h0});
        @(posedge clk);
        wr(OFF_PORT2, 8'h00);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("channel words", dac_code, {12'hFAB, 12'hCAB, 12'h534, 12'h1AB});
        $display("test channel latches done");
        @(posedge clk);
        supply_ok <= 1'b0;
        @(negedge clk);
        chk("por on dip", por_rst_n, 0);
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk("after dip", {zero_scale, dac_code}, {1'b1, 48'h0});
        @(posedge clk);
        supply_ok <= 1'b1;
        wait_por(n);
        chk("por again", n >= POR_SIM && n <= POR_SIM + 8, 1);
        rd(OFF_PORT2, 32'h80, "port2 after dip");
        $display("test supply dip done");
        wr(OFF_PORT1, 8'h08);
        chk("driver on", link_oe, 1);
        wr(OFF_TX, 8'hA5);
        rd(OFF_STATUS, 32'hB, "status busy");
        n = 0;
        while (got !== 1'b1 && n < 70000)
        begin
            @(posedge clk);
            n++;
        end
        // a capture that never finishes counts as a mismatch
        if (got !== 1'b1)
            num_errors++;
        chk("start bit", start_ok, 1);
        chk("first data bits", first_bits, 2'b01);
        chk("driver held", link_oe, 1);
        $display("test transmit done");
        end_of_test();
    end

    // watchdog: the transmit capture needs about 65100 cycles
    initial
    begin
        repeat (80000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule

// >>> aoc_uart.sv
module aoc_uart
    import aoc_pkg::*;
(
    input  wire logic       clk,       // system clock
    input  wire logic       rst_n,     // sync reset, low active
    input  wire logic       rx_pin,    // serial input from link receiver
    input  wire logic       pop,       // read strobe, one cycle
    input  wire logic       load,      // transmit buffer load pulse
    input  wire logic [7:0] tx_byte,   // byte to send
    output logic [7:0]      rx_data,   // last received word
    output logic            rx_ready,  // word waiting
    output logic            rx_new,    // pulse on each new word
    output logic            rx_err,    // overrun, framing or parity
    output logic            tx_line,   // serial output
    output logic            tx_busy,   // shifting
    output logic            tx_done    // pulse after stop bit
);

    aoc_uart_st_t s;
    aoc_uart_st_t next_s;

    // receive and transmit engines, 8 data bits, even parity, one stop
    always_comb
    begin
        next_s = s;
        next_s.rx_new  = 1'b0;
        next_s.tx_done = 1'b0;
        next_s.rx_sync = {s.rx_sync[1:0], rx_pin};
        // a change counts once second and third stage agree
        if (s.rx_sync[1] == s.rx_sync[2])
            next_s.rx_lvl = s.rx_sync[2];
        // clear first so a word landing this cycle still sets the flags
        if (pop)
        begin
            next_s.rx_ready = 1'b0;
            next_s.ovr = 1'b0;
            next_s.frm = 1'b0;
            next_s.perr = 1'b0;
        end
        if (s.rx_cnt != 16'h0000)
            next_s.rx_cnt = s.rx_cnt - 16'h0001;
        case (s.rx_st)
            ST_IDLE:
                if (!s.rx_lvl)
                begin
                    next_s.rx_st  = ST_START;
                    next_s.rx_cnt = 16'(HALF_CYC);
                end
            ST_START:
                if (s.rx_cnt == 16'h0000)
                begin
                    // a glitch shorter than half a bit is dropped
                    next_s.rx_st  = s.rx_lvl ? ST_IDLE : ST_DATA;
                    next_s.rx_cnt = 16'(BIT_CYC - 1);
                    next_s.rx_bit = 3'h0;
                    next_s.rx_par = 1'b0;
                end
            ST_DATA:
                if (s.rx_cnt == 16'h0000)
                begin
                    next_s.rx_sh  = {s.rx_lvl, s.rx_sh[7:1]};
                    next_s.rx_par = s.rx_par ^ s.rx_lvl;
                    next_s.rx_cnt = 16'(BIT_CYC - 1);
                    next_s.rx_bit = s.rx_bit + 3'h1;
                    if (s.rx_bit == 3'h7)
                        next_s.rx_st = ST_PAR;
                end
            ST_PAR:
                if (s.rx_cnt == 16'h0000)
                begin
                    next_s.rx_pbad = s.rx_par ^ s.rx_lvl;
                    next_s.rx_cnt  = 16'(BIT_CYC - 1);
                    next_s.rx_st   = ST_STOP;
                end
            ST_STOP:
                if (s.rx_cnt == 16'h0000)
                begin
                    next_s.ovr      = next_s.ovr | s.rx_ready;
                    next_s.frm      = next_s.frm | ~s.rx_lvl;
                    next_s.perr     = next_s.perr | s.rx_pbad;
                    next_s.rx_data  = s.rx_sh;
                    next_s.rx_ready = 1'b1;
                    next_s.rx_new   = 1'b1;
                    next_s.rx_st    = ST_IDLE;
                end
            default:
                next_s.rx_st = ST_IDLE;
        endcase
        // transmitter, a load while busy is ignored
        if (s.tx_cnt != 16'h0000)
            next_s.tx_cnt = s.tx_cnt - 16'h0001;
        case (s.tx_st)
            ST_IDLE:
                if (load)
                begin
                    next_s.tx_sh   = tx_byte;
                    next_s.tx_par  = ^tx_byte;
                    next_s.tx_line = 1'b0;
                    next_s.tx_cnt  = 16'(BIT_CYC - 1);
                    next_s.tx_st   = ST_START;
                end
            ST_START, ST_DATA:
                if (s.tx_cnt == 16'h0000)
                begin
                    next_s.tx_line = s.tx_sh[0];
                    next_s.tx_sh   = {1'b0, s.tx_sh[7:1]};
                    next_s.tx_cnt  = 16'(BIT_CYC - 1);
                    next_s.tx_bit  = (s.tx_st == ST_START) ? 3'h0
                                   : s.tx_bit + 3'h1;
                    if (s.tx_st == ST_START)
                        next_s.tx_st = ST_DATA;
                    else if (s.tx_bit == 3'h7)
                    begin
                        next_s.tx_line = s.tx_par;
                        next_s.tx_st   = ST_PAR;
                    end
                end
            ST_PAR:
                if (s.tx_cnt == 16'h0000)
                begin
                    next_s.tx_line = 1'b1;
                    next_s.tx_cnt  = 16'(BIT_CYC - 1);
                    next_s.tx_st   = ST_STOP;
                end
            ST_STOP:
                if (s.tx_cnt == 16'h0000)
                begin
                    next_s.tx_done = 1'b1;
                    next_s.tx_st   = ST_IDLE;
                end
            default:
                next_s.tx_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s         <= '0;
            s.rx_sync <= 3'h7;
            s.rx_lvl  <= 1'b1;
            s.rx_st   <= ST_IDLE;
            s.tx_st   <= ST_IDLE;
            s.tx_line <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign rx_data  = s.rx_data;
    assign rx_ready = s.rx_ready;
    assign rx_new   = s.rx_new;
    assign rx_err   = s.ovr | s.frm | s.perr;
    assign tx_line  = s.tx_line;
    assign tx_busy  = (s.tx_st != ST_IDLE);
    assign tx_done  = s.tx_done;

endmodule
